//--- src/api_response_frame_builder.sv
// builds identification and remote response frames as a byte stream
`timescale 1ns/1ps
module api_response_frame_builder (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic [7:0] API_OUTPUT_SELECT,
    input wire logic [7:0] DISCOVERY_OPTIONS,
    input wire logic NI_VALID,
    output logic NI_READY,
    input wire logic [63:0] NI_SRC_ADDR,
    input wire logic [7:0] NI_RX_OPTIONS,
    input wire logic [63:0] NI_REMOTE_ADDR,
    input wire logic [8*frame_pkg::NI_MAX_CHARS-1:0] NI_TEXT,
    input wire logic [4:0] NI_TEXT_LEN,
    input wire logic [7:0] NI_DEVICE_TYPE,
    input wire logic [7:0] NI_SOURCE_EVENT,
    input wire logic [31:0] NI_DEVICE_TYPE_ID,
    input wire logic [7:0] NI_RSSI,
    input wire logic RSP_VALID,
    output logic RSP_READY,
    input wire logic [7:0] RSP_FRAME_ID,
    input wire logic [63:0] RSP_ADDR,
    input wire logic [15:0] RSP_CMD,
    input wire logic [7:0] RSP_STATUS,
    input wire logic [8*frame_pkg::RSP_MAX_DATA-1:0] RSP_DATA,
    input wire logic [3:0] RSP_DATA_LEN,
    output logic [7:0] TX_DATA,
    output logic TX_VALID,
    input wire logic TX_READY,
    output logic BUSY
);
    import frame_pkg::*;

    // ****************************************
    // helpers
    // ****************************************

    // pick byte rel of a 64-bit address, msb first
    function automatic logic [7:0] addr_byte(input logic [63:0] a, input logic [2:0] rel);
        logic [63:0] s;
        s = a << {rel, 3'b000};
        return s[63:56];
    endfunction : addr_byte

    // pick byte k of a packed byte string, byte 0 in the low bits
    function automatic logic [7:0] str_byte(input logic [159:0] s, input logic [4:0] k);
        logic [159:0] t;
        t = s >> {k, 3'b000};
        return t[7:0];
    endfunction : str_byte

    // ****************************************
    // latched frame contents
    // ****************************************
    phase_t phase_r;               // byte position class
    kind_t kind_r;                 // which frame is in flight
    idx_t idx_r;                   // body byte offset
    idx_t last_r;                  // last body offset
    idx_t len_r;                   // frame-data length
    logic [63:0] addr_r;           // sender or responder address
    logic [63:0] remote_r;         // remote node address
    logic [159:0] text_r;          // identifier text or queried value
    logic [4:0] tlen_r;            // text or value length
    logic [7:0] opt_r;             // receive options
    logic [7:0] dtype_r;           // device role
    logic [7:0] event_r;           // source event
    logic [31:0] ddid_r;           // device type identifier
    logic [7:0] rssi_r;            // signal strength
    logic dd_en_r;                 // identifier field present
    logic rssi_en_r;               // strength field present
    logic [7:0] fid_r;             // request frame identifier
    logic [15:0] cmd_r;            // command name
    logic [7:0] status_r;          // command status

    byte_stream_if st ();          // builder to buffer
    logic push;                    // a byte enters the buffer
    logic ni_take;                 // identification request taken
    logic rsp_take;                // response request taken
    logic ni_emit;                 // taken identification gets a frame
    logic [4:0] ni_len;            // clamped text length
    idx_t ni_data_len;             // identification frame-data length
    idx_t rsp_data_len;            // response frame-data length
    idx_t text_end;                // offset of the null terminator
    idx_t tail_k;                  // offset past the terminator
    logic [7:0] body_byte;         // byte for the current offset
    logic [7:0] csum;              // checksum of sent frame data

    // ****************************************
    // request handshakes
    // ****************************************

    // responses win a tie: their requester waits on them
    assign RSP_READY = (phase_r == PH_IDLE);
    assign NI_READY = (phase_r == PH_IDLE) && !RSP_VALID;
    assign rsp_take = RSP_VALID && RSP_READY;
    assign ni_take = NI_VALID && NI_READY;
    // other output selects swallow the message silently
    assign ni_emit = ni_take && (API_OUTPUT_SELECT == 8'h00);
    assign BUSY = (phase_r != PH_IDLE);
    assign push = st.valid && st.ready;

    // over-long text is clipped rather than overrunning the frame
    assign ni_len = (NI_TEXT_LEN > 5'(NI_MAX_CHARS)) ? 5'(NI_MAX_CHARS) : NI_TEXT_LEN;

    // frame-data lengths, counted from the type byte
    always_comb begin
        ni_data_len = 7'(OFF_NI_TEXT + ni_len + 1'b1 - OFF_TYPE + NI_TAIL_BYTES);
        if (DISCOVERY_OPTIONS[OPT_DD_BIT]) begin
            ni_data_len = 7'(ni_data_len + DD_BYTES);
        end
        if (DISCOVERY_OPTIONS[OPT_RSSI_BIT]) begin
            ni_data_len = 7'(ni_data_len + 1'b1);
        end
        rsp_data_len = 7'(OFF_RSP_DATA - OFF_TYPE + RSP_DATA_LEN);
    end

    // ****************************************
    // capture of a taken request
    // ****************************************

    // fields stay stable for the whole frame
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            kind_r <= K_NI;
            addr_r <= '0;
            remote_r <= '0;
            text_r <= '0;
            tlen_r <= '0;
            opt_r <= '0;
            dtype_r <= '0;
            event_r <= '0;
            ddid_r <= '0;
            rssi_r <= '0;
            dd_en_r <= 1'b0;
            rssi_en_r <= 1'b0;
            fid_r <= '0;
            cmd_r <= '0;
            status_r <= '0;
            len_r <= '0;
        end else if (rsp_take) begin
            kind_r <= K_RSP;
            addr_r <= RSP_ADDR;
            text_r <= {96'h0, RSP_DATA};
            tlen_r <= {1'b0, RSP_DATA_LEN};
            fid_r <= RSP_FRAME_ID;
            cmd_r <= RSP_CMD;
            status_r <= RSP_STATUS;
            len_r <= rsp_data_len;
        end else if (ni_emit) begin
            kind_r <= K_NI;
            addr_r <= NI_SRC_ADDR;
            remote_r <= NI_REMOTE_ADDR;
            text_r <= NI_TEXT;
            tlen_r <= ni_len;
            opt_r <= NI_RX_OPTIONS;
            dtype_r <= NI_DEVICE_TYPE;
            event_r <= NI_SOURCE_EVENT;
            ddid_r <= NI_DEVICE_TYPE_ID;
            rssi_r <= NI_RSSI;
            dd_en_r <= DISCOVERY_OPTIONS[OPT_DD_BIT];
            rssi_en_r <= DISCOVERY_OPTIONS[OPT_RSSI_BIT];
            len_r <= ni_data_len;
        end
    end

    // ****************************************
    // sequencing
    // ****************************************

    // a full buffer holds the phase, so no byte is ever dropped
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            phase_r <= PH_IDLE;
            idx_r <= OFF_TYPE;
            last_r <= OFF_TYPE;
        end else begin
            case (phase_r)
                PH_IDLE: begin
                    idx_r <= OFF_TYPE;
                    if (rsp_take) begin
                        phase_r <= PH_DELIM;
                        last_r <= 7'(rsp_data_len + OFF_TYPE - 1'b1);
                    end else if (ni_emit) begin
                        phase_r <= PH_DELIM;
                        last_r <= 7'(ni_data_len + OFF_TYPE - 1'b1);
                    end
                end
                PH_DELIM: if (push) phase_r <= PH_LEN_HI;
                PH_LEN_HI: if (push) phase_r <= PH_LEN_LO;
                PH_LEN_LO: if (push) phase_r <= PH_BODY;
                PH_BODY: begin
                    if (push) begin
                        idx_r <= 7'(idx_r + 1'b1);
                        if (idx_r == last_r) phase_r <= PH_CSUM;
                    end
                end
                PH_CSUM: if (push) phase_r <= PH_IDLE;
                default: phase_r <= PH_IDLE;
            endcase
        end
    end

    // ****************************************
    // byte selection
    // ****************************************

    assign text_end = 7'(OFF_NI_TEXT + tlen_r);
    assign tail_k = 7'(idx_r - text_end - 1'b1);

    // one byte per offset, for whichever frame is in flight
    always_comb begin
        body_byte = RSVD_HI;
        if (kind_r == K_NI) begin
            if (idx_r == OFF_TYPE) begin
                body_byte = NI_TYPE;
            end else if (idx_r < OFF_NI_RSVD1) begin
                body_byte = addr_byte(addr_r, 3'(idx_r - OFF_NI_SRC));
            end else if (idx_r < OFF_NI_OPT) begin
                body_byte = (idx_r == OFF_NI_RSVD1) ? RSVD_HI : RSVD_LO;
            end else if (idx_r == OFF_NI_OPT) begin
                body_byte = opt_r;  // passed whole, host filters bits
            end else if (idx_r < OFF_NI_REMOTE) begin
                body_byte = (idx_r == OFF_NI_RSVD2) ? RSVD_HI : RSVD_LO;
            end else if (idx_r < OFF_NI_TEXT) begin
                body_byte = addr_byte(remote_r, 3'(idx_r - OFF_NI_REMOTE));
            end else if (idx_r < text_end) begin
                body_byte = str_byte(text_r, 5'(idx_r - OFF_NI_TEXT));
            end else if (idx_r == text_end) begin
                body_byte = NULL_BYTE;
            end else begin
                case (tail_k)
                    7'h00: body_byte = RSVD_HI;
                    7'h01: body_byte = RSVD_LO;
                    7'h02: body_byte = dtype_r;
                    7'h03: body_byte = event_r;
                    7'h04: body_byte = PROFILE_ID[15:8];
                    7'h05: body_byte = PROFILE_ID[7:0];
                    7'h06: body_byte = MFR_ID[15:8];
                    7'h07: body_byte = MFR_ID[7:0];
                    7'h08: body_byte = dd_en_r ? ddid_r[31:24] : rssi_r;
                    7'h09: body_byte = ddid_r[23:16];
                    7'h0a: body_byte = ddid_r[15:8];
                    7'h0b: body_byte = ddid_r[7:0];
                    default: body_byte = rssi_r;
                endcase
            end
        end else begin
            if (idx_r == OFF_TYPE) begin
                body_byte = RSP_TYPE;
            end else if (idx_r == OFF_RSP_FID) begin
                body_byte = fid_r;
            end else if (idx_r < OFF_RSP_RSVD) begin
                body_byte = addr_byte(addr_r, 3'(idx_r - OFF_RSP_ADDR));
            end else if (idx_r < OFF_RSP_CMD) begin
                body_byte = (idx_r == OFF_RSP_RSVD) ? RSVD_HI : RSVD_LO;
            end else if (idx_r < OFF_RSP_STATUS) begin
                body_byte = (idx_r == OFF_RSP_CMD) ? cmd_r[15:8] : cmd_r[7:0];
            end else if (idx_r == OFF_RSP_STATUS) begin
                body_byte = status_r;
            end else begin
                body_byte = str_byte(text_r, 5'(idx_r - OFF_RSP_DATA));
            end
        end
    end

    // framing bytes around the body
    always_comb begin
        st.valid = (phase_r != PH_IDLE);
        case (phase_r)
            PH_DELIM: st.data = DELIM_BYTE;
            PH_LEN_HI: st.data = ZERO_BYTE;
            PH_LEN_LO: st.data = {1'b0, len_r};
            PH_BODY: st.data = body_byte;
            PH_CSUM: st.data = csum;
            default: st.data = ZERO_BYTE;
        endcase
    end

    // ****************************************
    // checksum and output buffer
    // ****************************************

    frame_checksum u_csum (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .clr(phase_r == PH_DELIM),
        .add(push && (phase_r == PH_BODY)),
        .data(st.data),
        .csum(csum)
    );

    // the buffer decouples the host's pace from frame building
    byte_fifo #(.W(BYTE_W), .D(FIFO_DEPTH)) u_fifo (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .in_s(st),
        .out_data(TX_DATA),
        .out_valid(TX_VALID),
        .out_ready(TX_READY)
    );

    // ****************************************
    // checks
    // ****************************************

    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RST_N);

    sequence s_rsp_taken;
        RSP_VALID && RSP_READY;
    endsequence
    sequence s_delim_out;
        push && (phase_r == PH_DELIM);
    endsequence

    chk_rsp_frame_start: assert property (s_rsp_taken |=> phase_r == PH_DELIM ##0 kind_r == K_RSP)
        else $error("response request did not start a frame");
    chk_ni_muted_select: assert property (ni_take && API_OUTPUT_SELECT != 8'h00 |=> phase_r == PH_IDLE)
        else $error("identification sent while output select nonzero");
    chk_frame_header: assert property (s_delim_out |-> st.data == 8'h7e ##1 phase_r == PH_LEN_HI)
        else $error("delimiter or header order wrong");
    chk_ni_type_byte: assert property (push && kind_r == K_NI && phase_r == PH_BODY && idx_r == 7'h03 |-> st.data == 8'h95)
        else $error("identification type byte wrong");
    chk_ni_src_msb: assert property (push && kind_r == K_NI && phase_r == PH_BODY && idx_r == 7'h04 |-> st.data == addr_r[63:56])
        else $error("sender address msb misplaced");
    chk_ni_remote_lsb: assert property (push && kind_r == K_NI && phase_r == PH_BODY && idx_r == 7'h18 |-> st.data == remote_r[7:0])
        else $error("remote address lsb misplaced");
    chk_ni_text_null: assert property (push && kind_r == K_NI && phase_r == PH_BODY && idx_r == text_end |-> st.data == 8'h00)
        else $error("identifier text not terminated");
    chk_ni_profile_id: assert property (push && kind_r == K_NI && phase_r == PH_BODY && tail_k == 7'h04 && idx_r > text_end |-> st.data == PROFILE_ID[15:8])
        else $error("profile code misplaced");
    chk_rsp_fid_echo: assert property (push && kind_r == K_RSP && phase_r == PH_BODY && idx_r == 7'h04 |-> st.data == fid_r)
        else $error("frame identifier not echoed");
    chk_rsp_status_byte: assert property (push && kind_r == K_RSP && phase_r == PH_BODY && idx_r == 7'h11 |-> st.data == status_r)
        else $error("status byte misplaced");
    chk_rsvd_pair: assert property (push && phase_r == PH_BODY && idx_r == 7'h0d && kind_r == K_RSP |-> st.data == 8'hff)
        else $error("reserved pair wrong");
    // the offset has already stepped past the last body byte, even while a full buffer holds the checksum
    chk_len_matches: assert property (push && phase_r == PH_CSUM |-> idx_r == 7'(len_r + 7'h03))
        else $error("body length disagrees with length field");

endmodule : api_response_frame_builder

//--- src/byte_fifo.sv
// parameterised fifo with valid/ready on both sides
`timescale 1ns/1ps
module byte_fifo #(
    parameter int W = 8,
    parameter int D = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    byte_stream_if.snk in_s,
    output logic [W-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(D);

    logic [W-1:0] mem [D];       // storage words
    logic [AW-1:0] wr_r;         // write pointer
    logic [AW-1:0] rd_r;         // read pointer
    logic [AW:0] cnt_r;          // words held
    logic push;
    logic pop;

    // full and empty follow the true count
    assign in_s.ready = (cnt_r != AW'(0) + (AW+1)'(D)) ? 1'b1 : 1'b0;
    assign out_valid = (cnt_r != '0);
    assign push = in_s.valid && in_s.ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_r];

    // storage write, no reset needed on data
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_r] <= in_s.data;
        end
    end

    // pointers and count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) wr_r <= AW'(wr_r + 1'b1);
            if (pop) rd_r <= AW'(rd_r + 1'b1);
            cnt_r <= (AW+1)'(cnt_r + push - pop);
        end
    end
endmodule : byte_fifo

//--- src/byte_stream_if.sv
// valid/ready byte stream between builder and output buffer
`timescale 1ns/1ps
interface byte_stream_if;
    logic valid;        // byte offered
    logic ready;        // byte taken
    logic [7:0] data;   // byte value
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : byte_stream_if

//--- src/frame_checksum.sv
// running sum of frame-data bytes and the resulting checksum
`timescale 1ns/1ps
module frame_checksum (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clr,
    input wire logic add,
    input wire logic [7:0] data,
    output logic [7:0] csum
);
    import frame_pkg::*;
    logic [7:0] sum_r;  // low byte of the sum, carries drop naturally

    // accumulate while frame data leaves
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sum_r <= '0;
        end else if (clr) begin
            sum_r <= '0;
        end else if (add) begin
            sum_r <= 8'(sum_r + data);
        end
    end

    assign csum = 8'(CSUM_BASE - sum_r);
endmodule : frame_checksum

//--- src/frame_pkg.sv
// constants, offsets and types shared by the api frame builder files
package frame_pkg;

    // ****************************************
    // byte widths and sizes
    // ****************************************
    localparam int BYTE_W = 8;            // one serial byte
    localparam int FIFO_DEPTH = 32;       // bytes buffered toward the host
    localparam int NI_MAX_CHARS = 20;     // longest identifier text
    localparam int RSP_MAX_DATA = 8;      // longest queried value

    typedef logic [6:0] idx_t;            // byte offset within a frame

    // ****************************************
    // fixed byte values
    // ****************************************
    localparam logic [7:0] DELIM_BYTE = 8'h7e;  // frame start
    localparam logic [7:0] NI_TYPE = 8'h95;     // identification frame
    localparam logic [7:0] RSP_TYPE = 8'h97;    // remote response frame
    localparam logic [7:0] RSVD_HI = 8'hff;     // reserved pair, first
    localparam logic [7:0] RSVD_LO = 8'hfe;     // reserved pair, second
    localparam logic [7:0] NULL_BYTE = 8'h00;   // text terminator
    localparam logic [7:0] CSUM_BASE = 8'hff;   // checksum minuend
    localparam logic [7:0] ZERO_BYTE = 8'h00;   // length high byte
    // identity codes: arbitrary neutral values
    localparam logic [15:0] PROFILE_ID = 16'h0a5c;
    localparam logic [15:0] MFR_ID = 16'h0b6d;

    // ****************************************
    // offsets
    // ****************************************
    localparam idx_t OFF_TYPE = 7'h03;
    localparam idx_t OFF_NI_SRC = 7'h04;
    localparam idx_t OFF_NI_RSVD1 = 7'h0c;
    localparam idx_t OFF_NI_OPT = 7'h0e;
    localparam idx_t OFF_NI_RSVD2 = 7'h0f;
    localparam idx_t OFF_NI_REMOTE = 7'h11;
    localparam idx_t OFF_NI_TEXT = 7'h19;
    localparam idx_t NI_TAIL_BYTES = 7'h08;  // reserved, type, event, ids
    localparam idx_t DD_BYTES = 7'h04;
    localparam idx_t OFF_RSP_FID = 7'h04;
    localparam idx_t OFF_RSP_ADDR = 7'h05;
    localparam idx_t OFF_RSP_RSVD = 7'h0d;
    localparam idx_t OFF_RSP_CMD = 7'h0f;
    localparam idx_t OFF_RSP_STATUS = 7'h11;
    localparam idx_t OFF_RSP_DATA = 7'h12;

    // discovery option bits
    localparam int OPT_DD_BIT = 0;
    localparam int OPT_RSSI_BIT = 1;

    // ****************************************
    // state types
    // ****************************************
    typedef enum logic [2:0] {
        PH_IDLE, PH_DELIM, PH_LEN_HI, PH_LEN_LO, PH_BODY, PH_CSUM
    } phase_t;
    typedef enum logic {K_NI, K_RSP} kind_t;

endpackage : frame_pkg

//--- tb/api_response_frame_builder_tb.sv
// self-checking bench for the api frame builder
`timescale 1ns/1ps
`define CHK(n, e, s) begin samples_checked++; if ((e) !== (s)) begin failures++; \
$display("mismatch %s expected %h seen %h", n, e, s); end end
module api_response_frame_builder_tb;
    import frame_pkg::*;
    typedef logic [7:0] bq_t[$];
    // ****************************************
    // stimulus signals, all set at time zero
    // ****************************************
    logic clk = 1'b0, rst_n = 1'b0, ni_valid = 1'b0, rsp_valid = 1'b0, stall = 1'b0;
    logic [7:0] api_sel = 8'h00, disc_opt = 8'h00, ni_opt = 8'hc2, ni_type = 8'h01;
    logic [7:0] ni_event = 8'h01, ni_rssi = 8'h2e, fid = 8'h00, status = 8'h00;
    logic [63:0] ni_addr = 64'h0013a200407402ac, ni_raddr = 64'h0123456789abcdef;
    logic [63:0] rsp_addr = 64'h0013a20040522baa, rsp_data = 64'haa2b5240;
    logic [159:0] ni_text = 160'h20; // one space character
    logic [4:0] ni_len = 5'h01;
    logic [31:0] ni_dd = 32'h000c0000;
    logic [15:0] cmd = 16'h534c;
    logic [3:0] rsp_len = 4'h0;
    logic ni_ready, rsp_ready, tx_valid, tx_ready, busy;
    logic [7:0] tx_data;
    int failures = 0, samples_checked = 0;
    bq_t body; // expected frame data from offset 3
    always #2.5 clk = ~clk;
    api_response_frame_builder dut_u (.SYS_CLK(clk), .RST_N(rst_n),
        .API_OUTPUT_SELECT(api_sel), .DISCOVERY_OPTIONS(disc_opt),
        .NI_VALID(ni_valid), .NI_READY(ni_ready), .NI_SRC_ADDR(ni_addr),
        .NI_RX_OPTIONS(ni_opt), .NI_REMOTE_ADDR(ni_raddr), .NI_TEXT(ni_text),
        .NI_TEXT_LEN(ni_len), .NI_DEVICE_TYPE(ni_type), .NI_SOURCE_EVENT(ni_event),
        .NI_DEVICE_TYPE_ID(ni_dd), .NI_RSSI(ni_rssi), .RSP_VALID(rsp_valid),
        .RSP_READY(rsp_ready), .RSP_FRAME_ID(fid), .RSP_ADDR(rsp_addr), .RSP_CMD(cmd),
        .RSP_STATUS(status), .RSP_DATA(rsp_data), .RSP_DATA_LEN(rsp_len),
        .TX_DATA(tx_data), .TX_VALID(tx_valid), .TX_READY(tx_ready), .BUSY(busy));
    host_rx_model host_u (.clk(clk), .rst_n(rst_n), .tx_data(tx_data),
        .tx_valid(tx_valid), .stall(stall), .tx_ready(tx_ready));
    // ****************************************
    // shared tasks
    // ****************************************
    function automatic bq_t be64(input logic [63:0] v);
        return {v[63:56], v[55:48], v[47:40], v[39:32], v[31:24], v[23:16], v[15:8], v[7:0]};
    endfunction : be64
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test
    // request held from one rising edge until ready is seen high at an edge
    task automatic handshake(input logic rsp);
        int t;
        t = 0;
        @(posedge clk);
        rsp_valid <= rsp;
        ni_valid <= !rsp;
        do begin
            @(negedge clk);
            t++;
        end while ((rsp ? rsp_ready : ni_ready) !== 1'b1 && t < 50);
        if (t == 50) begin
            failures++;
            end_of_test();
        end
        @(posedge clk);
        rsp_valid <= 1'b0;
        ni_valid <= 1'b0;
    endtask : handshake
    // wraps the expected data and compares byte for byte with what the host got
    task automatic check_frame();
        logic [7:0] sum;
        bq_t exp_q;
        int t;
        sum = 8'h00;
        t = 0;
        foreach (body[k]) sum = sum + body[k];
        sum = 8'hff - sum;
        exp_q = {8'h7e, 8'h00, 8'(body.size()), body, sum};
        while (host_u.rx_q.size() < exp_q.size() && t < 400) begin
            @(posedge clk);
            t++;
        end
        if (t == 400) begin
            failures++;
            end_of_test();
        end
        repeat (4) @(posedge clk);
        `CHK("byte count", exp_q.size(), host_u.rx_q.size())
        foreach (exp_q[k]) `CHK("frame byte", exp_q[k], host_u.rx_q[k])
        host_u.rx_q.delete();
    endtask : check_frame
    // ****************************************
    // scenarios
    // ****************************************
    // every status code; only the query carries a value
    task automatic scen_rsp();
        for (int s = 0; s < 4; s++) begin
            @(posedge clk);
            status <= 8'(s);
            fid <= 8'(8'h55 + s);
            rsp_len <= (s == 0) ? 4'h4 : 4'h0;
            handshake(1'b1);
            body = {8'h97, 8'(8'h55 + s), be64(64'h0013a20040522baa), 8'hff, 8'hfe};
            body = {body, 8'h53, 8'h4c, 8'(s)};
            if (s == 0) body = {body, 8'h40, 8'h52, 8'h2b, 8'haa};
            check_frame();
        end
    endtask : scen_rsp
    // a nonzero output select swallows the identification
    task automatic scen_drop();
        @(posedge clk);
        api_sel <= 8'h01;
        handshake(1'b0);
        repeat (40) @(posedge clk);
        `CHK("dropped bytes", 0, host_u.rx_q.size())
        api_sel <= 8'h00;
    endtask : scen_drop
    // optional fields per option bit; the longest frame overfills a stalled buffer
    task automatic scen_ni(input logic [7:0] opt);
        @(posedge clk);
        disc_opt <= opt;
        stall <= (opt == 8'h03);
        handshake(1'b0);
        body = {8'h95, be64(64'h0013a200407402ac), 8'hff, 8'hfe, 8'hc2, 8'hff, 8'hfe};
        body = {body, be64(64'h0123456789abcdef), 8'h20, 8'h00, 8'hff, 8'hfe, 8'h01};
        body = {body, 8'h01, PROFILE_ID[15:8], PROFILE_ID[7:0], MFR_ID[15:8], MFR_ID[7:0]};
        if (opt[0]) body = {body, 8'h00, 8'h0c, 8'h00, 8'h00};
        if (opt[1]) body = {body, 8'h2e};
        if (opt == 8'h03) begin
            repeat (60) @(negedge clk);
            `CHK("busy while full", 1'b1, busy)
            @(posedge clk);
            stall <= 1'b0;
        end
        check_frame();
    endtask : scen_ni
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        scen_rsp();
        scen_drop();
        for (int o = 0; o < 4; o++) begin
            scen_ni(8'(o));
        end
        end_of_test();
    end
endmodule : api_response_frame_builder_tb

//--- tb/host_rx_model.sv
// host model that drains the builder's byte stream
`timescale 1ns/1ps
module host_rx_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    input wire logic stall,
    output logic tx_ready
);
    logic [7:0] rx_q[$]; // bytes in arrival order
    // a stalled host takes nothing, so the buffer fills and the builder must wait
    assign tx_ready = !stall;
    // every byte is kept raw; option bits are left uninterpreted
    // frames from successive requests may arrive back to back, each is simply queued
    always @(posedge clk) begin
        if (rst_n && tx_valid && tx_ready) begin
            rx_q.push_back(tx_data);
        end
    end
endmodule : host_rx_model
